/* File: inc/adc_sel_pkg.sv */
// Purpose: Shared constants and types for the converter channel block
// Assumes: 8-bit register port with byte addresses as printed
// Notes:   Channel codes are six bits, high bit buffered separately
package adc_sel_pkg;
  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA_LOW = 8'h78;
  localparam logic [7:0] ADDR_DATA_HIGH = 8'h79;
  localparam logic [7:0] ADDR_CTRL_B = 8'h7b;
  localparam logic [7:0] ADDR_MUX = 8'h7c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h7e;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h7f;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTLB_SUPPLY_GOOD = 7;
  localparam int CTLB_CMP_MUX = 6;
  localparam int CTLB_REF_GOOD = 5;
  localparam int CTLB_CHAN_RESET = 4;
  localparam int CTLB_CHAN_HIGH = 3;
  localparam int MUX_ALIGN = 5;
  localparam logic [7:0] RESET_CTRL_B = 8'h00;
  localparam logic [7:0] RESET_MUX = 8'h00;
  localparam logic [5:0] RESET_CODE = 6'h00;
  localparam logic [3:0] RESET_IRQ = 4'h0;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // Interrupt status bits
  // ----------------------------------------------------------------
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_SUPPLY = 1;
  localparam int IRQ_REF = 2;
  localparam int IRQ_RESET = 3;

  // ----------------------------------------------------------------
  // Special selection codes
  // ----------------------------------------------------------------
  localparam logic [5:0] CODE_BANDGAP = 6'h1e;
  localparam logic [5:0] CODE_GROUND = 6'h1f;
  localparam logic [5:0] CODE_TEMP = 6'h29;
  localparam logic [5:0] CODE_BACKBIAS_P = 6'h34;
  localparam logic [5:0] CODE_BACKBIAS_N = 6'h3d;
  localparam logic [2:0] DIFF_LAST_PAIR = 3'h5;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_PIN, SRC_BANDGAP, SRC_GROUND, SRC_TEMP,
    SRC_BACKBIAS_P, SRC_BACKBIAS_N
  } src_kind_t;

  typedef enum logic [1:0] {GAIN_1X, GAIN_10X, GAIN_200X} gain_t;

  typedef enum logic [1:0] {RST_IDLE, RST_WAIT, RST_FIRE} rst_state_t;
endpackage

/* File: verilog/channel_code_decoder.sv */
// Purpose: Decode a six-bit channel code into input, pair and gain
// Assumes: Purely combinational; the caller registers the outputs
// Notes:   Reserved codes give SRC_NONE and no defined input
`timescale 1ns/100ps
module channel_code_decoder
(
  // Code in
  input wire logic [5:0] code,
  // Selection out
  output adc_sel_pkg::src_kind_t kind,
  output logic [2:0] pos_pin,
  output logic [2:0] neg_pin,
  output logic differential,
  output adc_sel_pkg::gain_t gain
);
  always_comb
  begin
    kind = adc_sel_pkg::SRC_NONE;
    pos_pin = 3'h0;
    neg_pin = 3'h0;
    differential = 1'b0;
    gain = adc_sel_pkg::GAIN_1X;
    case (code[5:3])
      3'h0:
      begin
        kind = adc_sel_pkg::SRC_PIN;
        pos_pin = code[2:0];
      end
      3'h1:
      begin
        // Pairs on inputs 0/1 and 2/3, negative side 0 or 2
        kind = adc_sel_pkg::SRC_PIN;
        differential = 1'b1;
        pos_pin = {1'b0, code[2], code[0]};
        neg_pin = {1'b0, code[2], 1'b0};
        gain = code[1] ? adc_sel_pkg::GAIN_200X : adc_sel_pkg::GAIN_10X;
      end
      3'h2:
      begin
        kind = adc_sel_pkg::SRC_PIN;
        differential = 1'b1;
        pos_pin = code[2:0];
        neg_pin = 3'h1;
      end
      default:
      begin
        if (code[5:3] == 3'h3 && code[2:0] <= adc_sel_pkg::DIFF_LAST_PAIR)
        begin
          kind = adc_sel_pkg::SRC_PIN;
          differential = 1'b1;
          pos_pin = code[2:0];
          neg_pin = 3'h2;
        end
        else
        begin
          case (code)
            adc_sel_pkg::CODE_BANDGAP: kind = adc_sel_pkg::SRC_BANDGAP;
            adc_sel_pkg::CODE_GROUND: kind = adc_sel_pkg::SRC_GROUND;
            adc_sel_pkg::CODE_TEMP:
            begin
              kind = adc_sel_pkg::SRC_TEMP;
              differential = 1'b1;
              gain = adc_sel_pkg::GAIN_10X;
            end
            adc_sel_pkg::CODE_BACKBIAS_P:
            begin
              kind = adc_sel_pkg::SRC_BACKBIAS_P;
              differential = 1'b1;
            end
            adc_sel_pkg::CODE_BACKBIAS_N:
            begin
              kind = adc_sel_pkg::SRC_BACKBIAS_N;
              differential = 1'b1;
            end
            default: kind = adc_sel_pkg::SRC_NONE;
          endcase
        end
      end
    endcase
  end
endmodule

/* File: verilog/adc_channel_select_status.sv */
// Purpose: Channel, alignment and analog status control of the converter
// Assumes: Conversion engine on clk_sys drives busy, done and result
// Notes:   Status pins from the analog side pass two-flop synchronisers
//
// Function
// - Alignment bit one presents result left adjusted, zero right adjusted.
// - Alignment change alters data register view at once, even mid-conversion.
// - Low five select bits written mid-conversion apply only after completion.
// - Upper select bit likewise waits for the running conversion to complete.
// - Upper select bit is buffered and committed by a low-bits write.
// - Upper bit and five low bits form one six-bit selection code.
// - Codes 0-7 pick inputs 0-7; 011110 bandgap, 011111 ground.
// - Codes 001xxx differential 10x/200x; 010000-011101 differential 1x.
// - Code 110100 positive, 111101 negative back-bias voltage to converter.
// - Converter enable requests analog supply unless another group already did.
// - Read-only bit seven reads one once the analog supply is up.
// - Converter enable switches on the chosen internal reference.
// - Read-only bit five reads one once the reference nears final level.
// - Writing one to channel-change bit forces analog blocks reset.
// - Channel-change bit reads one until reset phase can begin.
// - Bit six is read-write, serving only the comparator multiplexer.
// - Three-bit trigger source field, zero meaning free running.
`timescale 1ns/100ps
module adc_channel_select_status
#(
  parameter int RESULT_W = 10
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Conversion engine
  input wire logic converter_enable,
  input wire logic conversion_busy,
  input wire logic conversion_done,
  input wire logic [RESULT_W-1:0] conv_result,
  input wire logic other_supply_request,
  // Analog status pins
  input wire logic supply_good_pin,
  input wire logic reference_good_pin,
  input wire logic reset_ready_pin,
  // Channel selection
  output logic [5:0] active_code,
  output adc_sel_pkg::src_kind_t source_kind,
  output logic [2:0] pos_pin,
  output logic [2:0] neg_pin,
  output logic differential,
  output adc_sel_pkg::gain_t gain,
  output logic code_reserved,
  // Analog control
  output logic supply_request,
  output logic reference_enable,
  output logic [1:0] reference_select,
  output logic analog_reset,
  output logic [2:0] trigger_source_select,
  output logic comparator_mux_enable,
  output logic result_valid,
  // Interrupt
  output logic irq
);
  localparam int PAD_W = adc_sel_pkg::DATA_W - RESULT_W;

  if (RESULT_W < 8 || RESULT_W > 15)
  begin : g_bad_width
    $error("RESULT_W must lie between 8 and 15");
  end

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [2:0] sync_prev_ff;
  assign pin_raw = {reset_ready_pin, reference_good_pin, supply_good_pin};

  for (genvar i = 0; i < 3; i++)
  begin : g_sync
    always_ff @(posedge clk_sys)
    begin
      if (!rst_n)
      begin
        sync1_ff[i] <= 1'b0;
        sync2_ff[i] <= 1'b0;
        sync_prev_ff[i] <= 1'b0;
      end
      else
      begin
        sync1_ff[i] <= pin_raw[i];
        sync2_ff[i] <= sync1_ff[i];
        sync_prev_ff[i] <= sync2_ff[i];
      end
    end
  end

  logic supply_good_s;
  logic ref_good_s;
  logic ready_s;
  assign supply_good_s = sync2_ff[0];
  assign ref_good_s = sync2_ff[1];
  assign ready_s = sync2_ff[2];

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic wr_mux;
  logic wr_ctrl_b;
  logic wr_status;
  logic wr_mask;
  assign wr_mux = reg_wr && reg_addr == adc_sel_pkg::ADDR_MUX;
  assign wr_ctrl_b = reg_wr && reg_addr == adc_sel_pkg::ADDR_CTRL_B;
  assign wr_status = reg_wr && reg_addr == adc_sel_pkg::ADDR_IRQ_STATUS;
  assign wr_mask = reg_wr && reg_addr == adc_sel_pkg::ADDR_IRQ_MASK;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [1:0] ref_sel_ff;
  logic align_ff;
  logic [4:0] low_ff;
  logic high_buf_ff;
  logic cmp_mux_ff;
  logic [2:0] trig_ff;
  logic [adc_sel_pkg::IRQ_W-1:0] mask_ff;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      {ref_sel_ff, align_ff, low_ff} <= adc_sel_pkg::RESET_MUX;
      high_buf_ff <= 1'b0;
      cmp_mux_ff <= 1'b0;
      trig_ff <= 3'h0;
      mask_ff <= adc_sel_pkg::RESET_IRQ;
    end
    else
    begin
      if (wr_mux)
        {ref_sel_ff, align_ff, low_ff} <= reg_wdata;
      if (wr_ctrl_b)
      begin
        cmp_mux_ff <= reg_wdata[adc_sel_pkg::CTLB_CMP_MUX];
        high_buf_ff <= reg_wdata[adc_sel_pkg::CTLB_CHAN_HIGH];
        trig_ff <= reg_wdata[2:0];
      end
      if (wr_mask)
        mask_ff <= reg_wdata[adc_sel_pkg::IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Deferred channel commit
  // ----------------------------------------------------------------
  // The engine may sample the code at any time during a conversion,
  // so the applied code only moves when no conversion is running.
  logic pend_ff;
  logic [5:0] pend_code_ff;
  logic [5:0] code_ff;
  logic idle_now;
  logic [5:0] nxt_code;
  logic nxt_pend;
  assign idle_now = !conversion_busy || conversion_done;
  assign nxt_code = (wr_mux && idle_now) ? {high_buf_ff, reg_wdata[4:0]}
                  : (pend_ff && idle_now) ? pend_code_ff : code_ff;
  assign nxt_pend = wr_mux ? !idle_now : (pend_ff && !idle_now);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pend_ff <= 1'b0;
      pend_code_ff <= adc_sel_pkg::RESET_CODE;
      code_ff <= adc_sel_pkg::RESET_CODE;
    end
    else
    begin
      pend_ff <= nxt_pend;
      if (wr_mux)
        pend_code_ff <= {high_buf_ff, reg_wdata[4:0]};
      code_ff <= nxt_code;
    end
  end

  // ----------------------------------------------------------------
  // Selection outputs
  // ----------------------------------------------------------------
  adc_sel_pkg::src_kind_t dec_kind;
  logic [2:0] dec_pos;
  logic [2:0] dec_neg;
  logic dec_diff;
  adc_sel_pkg::gain_t dec_gain;

  channel_code_decoder u_decode
  (
    .code(code_ff),
    .kind(dec_kind),
    .pos_pin(dec_pos),
    .neg_pin(dec_neg),
    .differential(dec_diff),
    .gain(dec_gain)
  );

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      active_code <= adc_sel_pkg::RESET_CODE;
      source_kind <= adc_sel_pkg::SRC_PIN;
      pos_pin <= 3'h0;
      neg_pin <= 3'h0;
      differential <= 1'b0;
      gain <= adc_sel_pkg::GAIN_1X;
      code_reserved <= 1'b0;
    end
    else
    begin
      active_code <= code_ff;
      source_kind <= dec_kind;
      pos_pin <= dec_pos;
      neg_pin <= dec_neg;
      differential <= dec_diff;
      gain <= dec_gain;
      code_reserved <= dec_kind == adc_sel_pkg::SRC_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Result capture and alignment
  // ----------------------------------------------------------------
  logic [RESULT_W-1:0] result_ff;
  logic [adc_sel_pkg::DATA_W-1:0] view;
  assign view = align_ff ? {result_ff, {PAD_W{1'b0}}}
                         : {{PAD_W{1'b0}}, result_ff};

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      result_ff <= '0;
      result_valid <= 1'b0;
    end
    else if (conversion_done)
    begin
      result_ff <= conv_result;
      // result from reserved code is void
      result_valid <= dec_kind != adc_sel_pkg::SRC_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Analog supply and reference
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      supply_request <= 1'b0;
      reference_enable <= 1'b0;
      reference_select <= 2'h0;
    end
    else
    begin
      supply_request <= converter_enable && !other_supply_request;
      reference_enable <= converter_enable && ref_sel_ff != 2'h0;
      reference_select <= ref_sel_ff;
    end
  end

  // ----------------------------------------------------------------
  // Forced analog reset
  // ----------------------------------------------------------------
  adc_sel_pkg::rst_state_t rst_state_ff;
  adc_sel_pkg::rst_state_t nxt_rst_state;
  logic reset_asked;
  assign reset_asked = wr_ctrl_b && reg_wdata[adc_sel_pkg::CTLB_CHAN_RESET];

  always_comb
  begin
    nxt_rst_state = rst_state_ff;
    case (rst_state_ff)
      adc_sel_pkg::RST_IDLE:
        if (reset_asked)
          nxt_rst_state = adc_sel_pkg::RST_WAIT;
      adc_sel_pkg::RST_WAIT:
        if (ready_s)
          nxt_rst_state = adc_sel_pkg::RST_FIRE;
      adc_sel_pkg::RST_FIRE:
        nxt_rst_state = adc_sel_pkg::RST_IDLE;
      default:
        nxt_rst_state = adc_sel_pkg::RST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rst_state_ff <= adc_sel_pkg::RST_IDLE;
      analog_reset <= 1'b0;
    end
    else
    begin
      rst_state_ff <= nxt_rst_state;
      analog_reset <= nxt_rst_state == adc_sel_pkg::RST_FIRE;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  logic [adc_sel_pkg::IRQ_W-1:0] status_ff;
  logic [adc_sel_pkg::IRQ_W-1:0] events;
  logic [adc_sel_pkg::IRQ_W-1:0] clr;
  logic [adc_sel_pkg::IRQ_W-1:0] nxt_status;
  assign events = {analog_reset, ref_good_s && !sync_prev_ff[1],
                   supply_good_s && !sync_prev_ff[0], conversion_done};
  assign clr = wr_status ? reg_wdata[adc_sel_pkg::IRQ_W-1:0] : '0;
  // Set beats a clear landing in the same cycle
  assign nxt_status = (status_ff & ~clr) | events;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      status_ff <= adc_sel_pkg::RESET_IRQ;
      irq <= 1'b0;
    end
    else
    begin
      status_ff <= nxt_status;
      irq <= |(nxt_status & mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] ctrl_b_view;
  logic [7:0] nxt_rdata;
  assign ctrl_b_view = {supply_good_s, cmp_mux_ff, ref_good_s,
                        rst_state_ff == adc_sel_pkg::RST_WAIT,
                        high_buf_ff, trig_ff};
  assign nxt_rdata =
    !reg_rd ? 8'h00
    : reg_addr == adc_sel_pkg::ADDR_DATA_LOW ? view[7:0]
    : reg_addr == adc_sel_pkg::ADDR_DATA_HIGH ? view[15:8]
    : reg_addr == adc_sel_pkg::ADDR_CTRL_B ? ctrl_b_view
    : reg_addr == adc_sel_pkg::ADDR_MUX ? {ref_sel_ff, align_ff, low_ff}
    : reg_addr == adc_sel_pkg::ADDR_IRQ_STATUS ? {4'h0, status_ff}
    : reg_addr == adc_sel_pkg::ADDR_IRQ_MASK ? {4'h0, mask_ff}
    : 8'h00;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= nxt_rdata;
  end

  assign trigger_source_select = trig_ff;
  assign comparator_mux_enable = cmp_mux_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_reset_req;
    reset_asked && rst_state_ff == adc_sel_pkg::RST_IDLE;
  endsequence

  sequence s_reset_fire;
    analog_reset ##1 !analog_reset;
  endsequence

  chk_align_high: assert property (
    reg_rd && reg_addr == adc_sel_pkg::ADDR_DATA_HIGH && align_ff
    |=> reg_rdata == $past(result_ff[RESULT_W-1 -: 8]))
    else $error("left adjusted high byte wrong");

  chk_align_now: assert property (
    wr_mux && reg_wdata[adc_sel_pkg::MUX_ALIGN] && conversion_busy
    ##1 !wr_mux ##1 reg_rd && reg_addr == adc_sel_pkg::ADDR_DATA_HIGH
    |=> reg_rdata == $past(result_ff[RESULT_W-1 -: 8]))
    else $error("alignment change not immediate");

  chk_hold_busy: assert property (
    conversion_busy && !conversion_done |=> $stable(code_ff))
    else $error("code changed during conversion");

  chk_high_wait: assert property (
    wr_ctrl_b && !pend_ff && !wr_mux |=> $stable(code_ff[5]))
    else $error("high bit applied without low write");

  chk_commit_idle: assert property (
    wr_mux && !conversion_busy
    |=> code_ff == {$past(high_buf_ff), $past(reg_wdata[4:0])})
    else $error("code not committed when idle");

  chk_pending_apply: assert property (
    pend_ff && conversion_done && !wr_mux |=> code_ff == $past(pend_code_ff))
    else $error("pending code not applied at done");

  chk_bandgap_code: assert property (
    code_ff == adc_sel_pkg::CODE_BANDGAP
    |=> source_kind == adc_sel_pkg::SRC_BANDGAP && !differential)
    else $error("bandgap code misdecoded");

  chk_gain_high: assert property (
    code_ff[5:3] == 3'h1 && code_ff[1]
    |=> gain == adc_sel_pkg::GAIN_200X && differential)
    else $error("high gain pair misdecoded");

  chk_backbias_n: assert property (
    code_ff == adc_sel_pkg::CODE_BACKBIAS_N
    |=> source_kind == adc_sel_pkg::SRC_BACKBIAS_N)
    else $error("negative back-bias misdecoded");

  chk_supply_req: assert property (
    converter_enable && !other_supply_request |=> supply_request)
    else $error("supply not requested");

  chk_supply_flag: assert property (
    reg_rd && reg_addr == adc_sel_pkg::ADDR_CTRL_B
    |=> reg_rdata[7] == $past(supply_good_s))
    else $error("supply flag wrong");

  chk_reset_wait: assert property (
    s_reset_req ##1 !ready_s |=> rst_state_ff == adc_sel_pkg::RST_WAIT)
    else $error("reset request dropped early");

  chk_reset_pulse: assert property (
    rst_state_ff == adc_sel_pkg::RST_WAIT && ready_s |=> s_reset_fire)
    else $error("analog reset pulse wrong");

  chk_irq_level: assert property (
    status_ff[adc_sel_pkg::IRQ_DONE] && mask_ff[adc_sel_pkg::IRQ_DONE]
    && !wr_mask && !wr_status |=> irq)
    else $error("interrupt not raised");
endmodule

/* File: dv/adc_channel_select_status_tb_top.sv */
// Purpose: Self-checking bench for the converter channel block
// Assumes: One clock; the bench drives every design input itself
// Notes:   Pins are held long enough to pass the two-flop synchronisers
`timescale 1ns/100ps
module adc_channel_select_status_tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic en = 1'b0;
  logic busy = 1'b0;
  logic done = 1'b0;
  logic other = 1'b0;
  logic [9:0] res = 10'h000;
  logic sup_pin = 1'b0;
  logic ref_pin = 1'b0;
  logic rdy_pin = 1'b0;
  logic [5:0] code;
  adc_sel_pkg::src_kind_t kind;
  adc_sel_pkg::gain_t gain;
  logic [2:0] pp, np, trig;
  logic [1:0] rsel;
  logic diff, rsv, sreq, refen, arst, cmux, rvalid, irq;
  int n_errors = 0;
  int checks = 0;

  always #25 clk_sys = ~clk_sys;

  adc_channel_select_status #(.RESULT_W(10)) u_adc_channel_select_status
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .converter_enable(en), .conversion_busy(busy),
    .conversion_done(done), .conv_result(res),
    .other_supply_request(other), .supply_good_pin(sup_pin),
    .reference_good_pin(ref_pin), .reset_ready_pin(rdy_pin),
    .active_code(code), .source_kind(kind), .pos_pin(pp), .neg_pin(np),
    .differential(diff), .gain(gain), .code_reserved(rsv),
    .supply_request(sreq), .reference_enable(refen),
    .reference_select(rsel), .analog_reset(arst),
    .trigger_source_select(trig), .comparator_mux_enable(cmux),
    .result_valid(rvalid), .irq(irq)
  );

  // ----------------------------------------------------------------
  // Bus cycles and checks
  // ----------------------------------------------------------------
  task automatic results();
    $display("mismatches %0d of %0d checks", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    cmp(reg_rdata, exp);
  endtask

  task automatic pulse_done(input logic [9:0] r);
    @(posedge clk_sys);
    done <= 1'b1;
    res <= r;
    @(posedge clk_sys);
    done <= 1'b0;
  endtask

  task automatic sel(input logic [5:0] c, input logic [2:0] k);
    wr(8'h7b, {4'h0, c[5], 3'h0});
    wr(8'h7c, {3'h0, c[4:0]});
    tick(3);
    cmp({2'h0, code}, {2'h0, c});
    cmp({5'h0, kind}, {5'h0, k});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_align();
    pulse_done(10'h2a5);
    busy <= 1'b1;
    rd(8'h78, 8'ha5);
    rd(8'h79, 8'h02);
    wr(8'h7c, 8'h20);
    rd(8'h79, 8'ha9);
    rd(8'h78, 8'h40);
    @(posedge clk_sys);
    busy <= 1'b0;
  endtask

  task automatic t_codes();
    wr(8'h7b, 8'h08);
    tick(3);
    cmp({2'h0, code}, 8'h00);
    sel(6'h00, adc_sel_pkg::SRC_PIN);
    sel(6'h07, adc_sel_pkg::SRC_PIN);
    sel(6'h1e, adc_sel_pkg::SRC_BANDGAP);
    sel(6'h1f, adc_sel_pkg::SRC_GROUND);
    sel(6'h0a, adc_sel_pkg::SRC_PIN);
    cmp({1'b0, pp, 1'b0, np}, 8'h00);
    cmp({5'h0, diff, gain}, {5'h0, 1'b1, adc_sel_pkg::GAIN_200X});
    sel(6'h1d, adc_sel_pkg::SRC_PIN);
    cmp({1'b0, pp, 1'b0, np}, 8'h52);
    cmp({5'h0, diff, gain}, {5'h0, 1'b1, adc_sel_pkg::GAIN_1X});
    sel(6'h34, adc_sel_pkg::SRC_BACKBIAS_P);
    sel(6'h3d, adc_sel_pkg::SRC_BACKBIAS_N);
    sel(6'h29, adc_sel_pkg::SRC_TEMP);
    cmp({5'h0, diff, gain}, {5'h0, 1'b1, adc_sel_pkg::GAIN_10X});
    sel(6'h20, adc_sel_pkg::SRC_NONE);
    cmp({7'h0, rsv}, 8'h01);
    sel(6'h3f, adc_sel_pkg::SRC_NONE);
  endtask

  // Both halves of the code change while a conversion runs
  task automatic t_defer();
    @(posedge clk_sys);
    busy <= 1'b1;
    wr(8'h7b, 8'h00);
    wr(8'h7c, 8'h03);
    tick(4);
    cmp({2'h0, code}, 8'h3f);
    pulse_done(10'h155);
    busy <= 1'b0;
    tick(3);
    cmp({2'h0, code}, 8'h03);
    cmp({7'h0, rvalid}, 8'h00);
  endtask

  task automatic t_analog();
    wr(8'h7c, 8'hc0);
    @(posedge clk_sys);
    en <= 1'b1;
    tick(3);
    cmp({7'h0, sreq}, 8'h01);
    cmp({5'h0, refen, rsel}, 8'h07);
    @(posedge clk_sys);
    other <= 1'b1;
    tick(3);
    cmp({7'h0, sreq}, 8'h00);
  endtask

  task automatic t_status();
    @(posedge clk_sys);
    ref_pin <= 1'b1;
    tick(6);
    cmp({7'h0, irq}, 8'h00);
    rd(8'h7b, 8'h20);
    wr(8'h7f, 8'h02);
    @(posedge clk_sys);
    sup_pin <= 1'b1;
    tick(6);
    cmp({7'h0, irq}, 8'h01);
    wr(8'h7b, 8'h00);
    rd(8'h7b, 8'ha0);
    wr(8'h7e, 8'h02);
    tick(3);
    cmp({7'h0, irq}, 8'h00);
    // Done flag is still set from the earlier conversions
    wr(8'h7f, 8'h01);
    tick(2);
    cmp({7'h0, irq}, 8'h01);
    wr(8'h7e, 8'h01);
    tick(2);
    cmp({7'h0, irq}, 8'h00);
  endtask

  task automatic t_chreset();
    int n;
    wr(8'h7b, 8'h10);
    tick(4);
    rd(8'h7b, 8'hb0);
    cmp({7'h0, arst}, 8'h00);
    @(posedge clk_sys);
    rdy_pin <= 1'b1;
    n = 0;
    while (arst !== 1'b1 && n < 20)
    begin
      tick(1);
      n++;
    end
    cmp({7'h0, arst}, 8'h01);
    if (arst !== 1'b1)
      results();
    tick(1);
    cmp({7'h0, arst}, 8'h00);
    rd(8'h7b, 8'ha0);
  endtask

  task automatic t_ctrlb();
    wr(8'h7b, 8'h47);
    rd(8'h7b, 8'he7);
    cmp({4'h0, cmux, trig}, 8'h0f);
    cmp({2'h0, code}, 8'h00);
  endtask

  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(adc_sel_pkg::ADDR_CTRL_B, adc_sel_pkg::RESET_CTRL_B);
    rd(adc_sel_pkg::ADDR_MUX, adc_sel_pkg::RESET_MUX);
    rd(8'h70, 8'h00);
    t_align();
    t_codes();
    t_defer();
    t_analog();
    t_status();
    t_chreset();
    t_ctrlb();
    results();
  end
endmodule
